/* File: core/byte_alu_bit_skip_exec.sv */
// execution datapath for byte add/and, bit set/clear and bit-test skips
//
// Behaviour
// - add-immediate adds the 8-bit literal to the accumulator and updates all three flags.
// - add-register sums the accumulator and the addressed register and updates all three flags.
// - register-operand add/and write the accumulator on target 0 and the register on target 1.
// - and-immediate ands the literal into the accumulator and updates only the zero flag.
// - and-register ands with the addressed register, writes the chosen target, updates only zero.
// - bit-clear zeroes the chosen bit of the register leaving other bits and flags alone.
// - bit-set forces the chosen bit of the register to one leaving other bits and flags alone.
// - skip-if-set discards the following instruction as a no-op when the tested bit is one.
// - skip-if-clear discards the following instruction as a no-op when the tested bit is zero.
// - read-modify-write of a pin-backed register takes the pin levels, not the latch.
`timescale 1ns/1ps
`default_nettype none
module byte_alu_bit_skip_exec (
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    issue_valid,
    input  wire byte_alu_pkg::instr_t    instr,
    input  wire logic [1:0][7:0]         pin_levels,
    input  wire logic [6:0]              peek_addr,
    output logic [7:0]                   acc_out,
    output byte_alu_pkg::flags_t         flags_out,
    output logic [1:0][7:0]              port_latch,
    output logic                         nop_cycle,
    output logic [7:0]                   peek_data
);
    import byte_alu_pkg::*;

    logic [7:0]  acc_q;
    flags_t      flags_q;
    logic [7:0]  mem_q [REG_DEPTH];
    logic [7:0]  latch_q [NUM_PORTS];
    logic        squash_q;
    logic [7:0]  peek_q;

    logic        exec;
    logic [7:0]  src;
    logic        src_is_port;
    logic [7:0]  alu_b;
    logic        alu_and;
    logic [7:0]  alu_res;
    flags_t      alu_flags;
    logic [7:0]  bit_res;
    logic        test_bit;
    logic        skip_taken;
    logic        wr_acc;
    logic        wr_reg;
    logic [7:0]  wr_data;

    // an instruction that follows a taken skip is squashed into a no-op
    assign exec = issue_valid && !squash_q;

    // pin-backed registers read their pins so stray latch bits never leak back
    always_comb begin
        src         = mem_q[instr.reg_addr];
        src_is_port = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (instr.reg_addr == PORT_ADDR[i]) begin
                src         = pin_levels[i];
                src_is_port = 1'b1;
            end
        end
    end

    always_comb begin
        alu_b   = src;
        alu_and = 1'b0;
        unique case (instr.op)
            add_immediate_op: alu_b = instr.literal;
            and_immediate_op: begin
                alu_b   = instr.literal;
                alu_and = 1'b1;
            end
            and_register_op: alu_and = 1'b1;
            default: alu_b = src;
        endcase
    end

    byte_alu_core u_alu (
        .a      (acc_q),
        .b      (alu_b),
        .do_and (alu_and),
        .result (alu_res),
        .flags  (alu_flags)
    );

    always_comb begin
        bit_res  = src;
        bit_res[instr.position_index_field] = (instr.op == bit_set_op);
        test_bit = src[instr.position_index_field];
    end

    assign skip_taken = exec && (((instr.op == skip_if_bit_one_op) && test_bit)
                               || ((instr.op == skip_if_bit_zero_op) && !test_bit));

    always_comb begin
        wr_acc  = 1'b0;
        wr_reg  = 1'b0;
        wr_data = alu_res;
        if (exec) begin
            unique case (instr.op)
                add_immediate_op, and_immediate_op: wr_acc = 1'b1;
                add_register_op, and_register_op: begin
                    wr_acc = (instr.result_target_select == TARGET_ACC);
                    wr_reg = (instr.result_target_select == TARGET_REG);
                end
                bit_clear_op, bit_set_op: begin
                    wr_reg  = 1'b1;
                    wr_data = bit_res;
                end
                default: begin
                    wr_acc = 1'b0;
                    wr_reg = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc_q <= ACC_RESET;
        end else if (wr_acc) begin
            acc_q <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_q <= FLAGS_RESET;
        end else if (exec) begin
            unique case (instr.op)
                add_immediate_op, add_register_op: flags_q <= alu_flags;
                and_immediate_op, and_register_op: begin
                    flags_q.null_result_bit <= alu_flags.null_result_bit;
                end
                default: flags_q <= flags_q;
            endcase
        end
    end

    // storage rows behind a port address are never written; the latch is
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < REG_DEPTH; i++) begin
                mem_q[i] <= REG_RESET;
            end
        end else if (wr_reg && !src_is_port) begin
            mem_q[instr.reg_addr] <= wr_data;
        end
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                latch_q[p] <= LATCH_RESET;
            end else if (wr_reg && instr.reg_addr == PORT_ADDR[p]) begin
                latch_q[p] <= wr_data;
            end
        end
        assign port_latch[p] = latch_q[p];
    end

    // squash waits for the next issued instruction, however late it comes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            squash_q <= 1'b0;
        end else if (skip_taken) begin
            squash_q <= 1'b1;
        end else if (issue_valid) begin
            squash_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            peek_q <= REG_RESET;
        end else begin
            peek_q <= mem_q[peek_addr];
        end
    end

    assign acc_out   = acc_q;
    assign flags_out = flags_q;
    assign nop_cycle = squash_q;
    assign peek_data = peek_q;

    logic [8:0] chk_sum;
    assign chk_sum = {1'b0, acc_q} + {1'b0, src};

    property p_add_imm;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == add_immediate_op
        |=> acc_out == 8'($past(acc_q) + $past(instr.literal));
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate sum wrong");

    property p_add_reg_flags;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == add_register_op
        |=> flags_out.byte_overflow_bit == $past(chk_sum[8])
            && flags_out.null_result_bit == ($past(chk_sum[7:0]) == 8'h00);
    endproperty
    a_add_reg_flags: assert property (p_add_reg_flags) else $error("add flags wrong");

    property p_reg_target_keeps_acc;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op inside {add_register_op, and_register_op}
             && instr.result_target_select == TARGET_REG
        |=> $stable(acc_out);
    endproperty
    a_reg_target_keeps_acc: assert property (p_reg_target_keeps_acc) else $error("acc hit");

    property p_and_imm_keeps_carry;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == and_immediate_op
        |=> $stable(flags_out.byte_overflow_bit) && $stable(flags_out.nibble_overflow_bit)
            && acc_out == ($past(acc_q) & $past(instr.literal));
    endproperty
    a_and_imm_keeps_carry: assert property (p_and_imm_keeps_carry) else $error("and imm wrong");

    property p_and_reg_acc;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == and_register_op && instr.result_target_select == TARGET_ACC
        |=> acc_out == ($past(acc_q) & $past(src)) && $stable(flags_out.byte_overflow_bit);
    endproperty
    a_and_reg_acc: assert property (p_and_reg_acc) else $error("and reg wrong");

    property p_bit_clear;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == bit_clear_op && !src_is_port
        |=> mem_q[$past(instr.reg_addr)][$past(instr.position_index_field)] == 1'b0
            && $stable(flags_out);
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear failed");

    property p_bit_set;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == bit_set_op && !src_is_port
        |=> mem_q[$past(instr.reg_addr)][$past(instr.position_index_field)] == 1'b1
            && $stable(flags_out);
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set failed");

    property p_skip_one;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == skip_if_bit_one_op && test_bit ##1 issue_valid
        |=> $stable(acc_out) && !nop_cycle;
    endproperty
    a_skip_one: assert property (p_skip_one) else $error("skip on one not taken");

    property p_skip_zero;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == skip_if_bit_zero_op
        |=> nop_cycle == !$past(test_bit);
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");

    property p_port_from_pins;
        @(posedge clock) disable iff (!rstn)
        exec && instr.op == bit_set_op && instr.reg_addr == PORT_ADDR[0]
        |=> port_latch[0] == ($past(pin_levels[0])
                              | (8'h01 << $past(instr.position_index_field)));
    endproperty
    a_port_from_pins: assert property (p_port_from_pins) else $error("port rmw used latch");

    property p_single_cycle;
        @(posedge clock) disable iff (!rstn)
        exec && !(instr.op inside {skip_if_bit_one_op, skip_if_bit_zero_op})
        |=> !nop_cycle;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("extra cycle");

    c_skip_taken:  cover property (@(posedge clock) disable iff (!rstn)
                                   skip_taken ##1 (issue_valid && nop_cycle));
    c_add_carry:   cover property (@(posedge clock) disable iff (!rstn)
                                   exec && instr.op == add_register_op && chk_sum[8]);
    c_port_rmw:    cover property (@(posedge clock) disable iff (!rstn)
                                   wr_reg && src_is_port);
    c_reg_target:  cover property (@(posedge clock) disable iff (!rstn)
                                   exec && instr.op == and_register_op
                                   && instr.result_target_select == TARGET_REG);

endmodule : byte_alu_bit_skip_exec
`default_nettype wire

/* File: core/byte_alu_core.sv */
// combinational add / and unit with carry, half carry and zero
`timescale 1ns/1ps
`default_nettype none
module byte_alu_core (
    input  wire logic [7:0]   a,
    input  wire logic [7:0]   b,
    input  wire logic         do_and,
    output logic [7:0]        result,
    output byte_alu_pkg::flags_t flags
);
    import byte_alu_pkg::*;

    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum     = {1'b0, a} + {1'b0, b};
        low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        result  = do_and ? (a & b) : sum[7:0];
        flags.byte_overflow_bit   = sum[8];
        flags.nibble_overflow_bit = low_sum[4];
        flags.null_result_bit     = (result == 8'h00);
    end

endmodule : byte_alu_core
`default_nettype wire

/* File: core/byte_alu_pkg.sv */
// shared types and constants for the byte execution datapath
package byte_alu_pkg;

    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 7;
    localparam int REG_DEPTH  = 128;
    localparam int NUM_PORTS  = 2;

    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic       TARGET_ACC = 1'b0;
    localparam logic       TARGET_REG = 1'b1;

    // register addresses that are backed by pins instead of storage
    localparam logic [6:0] PORT_ADDR [NUM_PORTS] = '{7'h05, 7'h06};

    localparam int OP_CYCLES   = 1;
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [3:0] {
        nop_op              = 4'h0,
        add_immediate_op    = 4'h1,
        add_register_op     = 4'h2,
        and_immediate_op    = 4'h3,
        and_register_op     = 4'h4,
        bit_clear_op        = 4'h5,
        bit_set_op          = 4'h6,
        skip_if_bit_one_op  = 4'h7,
        skip_if_bit_zero_op = 4'h8
    } op_t;

    typedef struct packed {
        op_t         op;
        logic [7:0]  literal;
        logic [6:0]  reg_addr;
        logic        result_target_select;
        logic [2:0]  position_index_field;
    } instr_t;

    typedef struct packed {
        logic byte_overflow_bit;
        logic nibble_overflow_bit;
        logic null_result_bit;
    } flags_t;

    localparam flags_t FLAGS_RESET = '{1'b0, 1'b0, 1'b0};

endpackage : byte_alu_pkg

/* File: testbench/tb.sv */
// self-checking bench for the byte execution datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
    import byte_alu_pkg::*;

    logic             clock;
    logic             rstn;
    logic             issue_valid;
    instr_t           instr;
    logic [1:0][7:0]  pin_levels;
    logic [6:0]       peek_addr;
    logic [7:0]       acc_out;
    flags_t           flags_out;
    logic [1:0][7:0]  port_latch;
    logic             nop_cycle;
    logic [7:0]       peek_data;
    int               fails;
    int               total_checks;
    int               cycles;

    byte_alu_bit_skip_exec dut (
        .clock      (clock),
        .rstn       (rstn),
        .issue_valid(issue_valid),
        .instr      (instr),
        .pin_levels (pin_levels),
        .peek_addr  (peek_addr),
        .acc_out    (acc_out),
        .flags_out  (flags_out),
        .port_latch (port_latch),
        .nop_cycle  (nop_cycle),
        .peek_data  (peek_data)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // whole suite is about a hundred cycles, so 2000 only trips on a hang
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails = fails + 1;
            $display("wrong value at %0t: run timed out", $time);
            complete_run();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one issue cycle; valid drops after the taking edge, results settled on return
    task automatic issue(input op_t op, input logic [7:0] lit, input logic [6:0] addr,
                         input logic tgt, input logic [2:0] pos);
        @(posedge clock);
        issue_valid <= 1'b1;
        instr       <= '{op, lit, addr, tgt, pos};
        @(posedge clock);
        issue_valid <= 1'b0;
        #1;
    endtask : issue

    // two issues on consecutive edges, no idle cycle between them
    task automatic issue_two(input instr_t first, input instr_t second);
        @(posedge clock);
        issue_valid <= 1'b1;
        instr       <= first;
        @(posedge clock);
        instr       <= second;
        @(posedge clock);
        issue_valid <= 1'b0;
        #1;
    endtask : issue_two

    task automatic peek(input logic [6:0] addr, input logic [7:0] exp);
        @(posedge clock);
        peek_addr <= addr;
        @(posedge clock);
        @(posedge clock);
        #1;
        check(peek_data, exp, "stored byte");
    endtask : peek

    task automatic acc_flags(input logic [7:0] acc, input logic [2:0] fl);
        check(acc_out, acc, "accumulator");
        check({5'h00, flags_out}, {5'h00, fl}, "flags");
    endtask : acc_flags

    task automatic test_add_immediate;
        issue(add_immediate_op, 8'hF5, 7'h00, 1'b0, 3'h0);
        acc_flags(8'hF5, 3'h0);
        issue(add_immediate_op, 8'h10, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h05, 3'h4);
        issue(add_immediate_op, 8'hFB, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h00, 3'h7);
        $display("test add_immediate done, fails %0d", fails);
    endtask : test_add_immediate

    task automatic test_add_register;
        issue(add_immediate_op, 8'h3C, 7'h00, 1'b0, 3'h0);
        issue(add_register_op, 8'h00, 7'h10, TARGET_REG, 3'h0);
        acc_flags(8'h3C, 3'h0);
        peek(7'h10, 8'h3C);
        issue(add_register_op, 8'h00, 7'h10, TARGET_ACC, 3'h0);
        acc_flags(8'h78, 3'h2);
        peek(7'h10, 8'h3C);
        issue(add_register_op, 8'h00, 7'h7F, TARGET_ACC, 3'h0);
        acc_flags(8'h78, 3'h0);
        $display("test add_register done, fails %0d", fails);
    endtask : test_add_register

    task automatic test_and;
        issue(add_immediate_op, 8'h88, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h00, 3'h7);
        issue(add_immediate_op, 8'hF0, 7'h00, 1'b0, 3'h0);
        issue(add_immediate_op, 8'h20, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h10, 3'h4);
        // carry must survive the logic ops untouched
        issue(and_immediate_op, 8'h00, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h00, 3'h5);
        issue(add_immediate_op, 8'hF0, 7'h00, 1'b0, 3'h0);
        issue(and_register_op, 8'h00, 7'h10, TARGET_REG, 3'h0);
        acc_flags(8'hF0, 3'h0);
        peek(7'h10, 8'h30);
        issue(and_register_op, 8'h00, 7'h10, TARGET_ACC, 3'h0);
        acc_flags(8'h30, 3'h0);
        issue(and_immediate_op, 8'hFF, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h30, 3'h0);
        $display("test and done, fails %0d", fails);
    endtask : test_and

    task automatic test_bits;
        // 30h + D0h carries out of bit 7 but not out of bit 3
        issue(add_immediate_op, 8'hD0, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h00, 3'h5);
        issue(bit_set_op, 8'h00, 7'h10, 1'b0, 3'h7);
        peek(7'h10, 8'hB0);
        issue(bit_clear_op, 8'h00, 7'h10, 1'b0, 3'h4);
        peek(7'h10, 8'hA0);
        issue(bit_set_op, 8'h00, 7'h10, 1'b0, 3'h0);
        peek(7'h10, 8'hA1);
        acc_flags(8'h00, 3'h5);
        $display("test bits done, fails %0d", fails);
    endtask : test_bits

    task automatic test_skips;
        issue(skip_if_bit_one_op, 8'h00, 7'h10, 1'b0, 3'h7);
        check({7'h00, nop_cycle}, 8'h01, "skip taken");
        issue(add_immediate_op, 8'h01, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h00, 3'h5);
        check({7'h00, nop_cycle}, 8'h00, "skip over");
        issue(skip_if_bit_one_op, 8'h00, 7'h10, 1'b0, 3'h1);
        check({7'h00, nop_cycle}, 8'h00, "skip not taken");
        issue(add_immediate_op, 8'h01, 7'h00, 1'b0, 3'h0);
        acc_flags(8'h01, 3'h0);
        issue(skip_if_bit_zero_op, 8'h00, 7'h10, 1'b0, 3'h1);
        check({7'h00, nop_cycle}, 8'h01, "skip taken");
        issue(bit_set_op, 8'h00, 7'h10, 1'b0, 3'h1);
        peek(7'h10, 8'hA1);
        issue(skip_if_bit_zero_op, 8'h00, 7'h10, 1'b0, 3'h0);
        check({7'h00, nop_cycle}, 8'h00, "skip not taken");
        // back to back: the add right behind a taken skip must vanish
        issue_two('{skip_if_bit_one_op, 8'h00, 7'h10, 1'b0, 3'h7},
                  '{add_immediate_op, 8'h10, 7'h00, 1'b0, 3'h0});
        acc_flags(8'h01, 3'h0);
        check({7'h00, nop_cycle}, 8'h00, "squash cleared");
        $display("test skips done, fails %0d", fails);
    endtask : test_skips

    task automatic test_pins;
        // latch is 00h, so any 5Bh here must come from the pins
        issue(bit_set_op, 8'h00, PORT_ADDR[0], 1'b0, 3'h0);
        check(port_latch[0], 8'h5B, "port 0 latch");
        issue(add_immediate_op, 8'h00, 7'h00, 1'b0, 3'h0);
        issue(add_register_op, 8'h00, PORT_ADDR[1], TARGET_REG, 3'h0);
        check(port_latch[1], 8'hA6, "port 1 latch");
        issue(add_immediate_op, 8'h60, 7'h00, 1'b0, 3'h0);
        issue(add_register_op, 8'h00, PORT_ADDR[1], TARGET_ACC, 3'h0);
        acc_flags(8'h06, 3'h4);
        check(port_latch[1], 8'hA6, "port 1 latch kept");
        $display("test pins done, fails %0d", fails);
    endtask : test_pins

    initial begin
        rstn         = 1'b0;
        issue_valid  = 1'b0;
        instr        = '{nop_op, 8'h00, 7'h00, 1'b0, 3'h0};
        pin_levels   = '{8'hA5, 8'h5A};
        peek_addr    = 7'h00;
        fails        = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        #1;
        acc_flags(ACC_RESET, 3'h0);
        check({7'h00, nop_cycle}, 8'h00, "reset skip state");
        check(port_latch[0], LATCH_RESET, "reset latch");
        test_add_immediate();
        test_add_register();
        test_and();
        test_bits();
        test_skips();
        test_pins();
        complete_run();
    end
endmodule : tb
`default_nettype wire
